/* core/dstrec_pkg.sv */
// Shared constants and types for the disturbance recorder control block.
package dstrec_pkg;

  localparam int CLK_HZ          = 20000000;
  localparam int MAX_RECS        = 100;
  localparam int RECS_W          = 7;
  localparam int N_TRIG          = 16;
  localparam int N_ANA           = 8;
  localparam int N_DIG           = 16;
  localparam int CNT_W           = 5;
  localparam int SMP_W           = 16;
  // Times in milliseconds, except DIG_PERIOD_CYC and MS_CYC, in clock cycles.
  localparam int DIG_PERIOD_MS   = 5;
  localparam int DIG_PERIOD_CYC  = DIG_PERIOD_MS * (CLK_HZ / 1000);
  localparam int LEN_MIN_MS      = 100;
  localparam int LEN_MAX_MS      = 1800000;
  localparam int LEN_DEF_MS      = 1000;
  localparam int PRE_MIN_MS      = 200;
  localparam int PRE_MAX_MS      = 15000;
  localparam int PRE_DEF_MS      = 200;
  localparam int MS_W            = 21;
  localparam int MS_CYC          = CLK_HZ / 1000;
  // Total sample reserve and digital rate of the storage estimate.
  localparam int RESERVE_SMP     = 16076647;
  localparam int DIG_RATE_HZ     = 200;
  localparam int IDX_W           = 32;
  localparam int BUF_W           = N_ANA * SMP_W + N_DIG;

  typedef enum logic [1:0] {
    DSTREC_SR64,
    DSTREC_SR32,
    DSTREC_SR16,
    DSTREC_SR8
  } dstrec_rate_t;

  typedef enum logic [2:0] {
    DSTREC_ST_READY,
    DSTREC_ST_TRIGGERED,
    DSTREC_ST_REC_STORE,
    DSTREC_ST_STORING,
    DSTREC_ST_FULL,
    DSTREC_ST_BADCFG
  } dstrec_status_t;

  typedef struct packed {
    logic             enable;
    logic             keep_olds;
    dstrec_rate_t     rate;
    logic [MS_W-1:0]  len_ms;
    logic [MS_W-1:0]  pre_ms;
    logic [N_TRIG-1:0] trig_sel;
    logic [CNT_W-1:0] n_ana;
    logic [CNT_W-1:0] n_dig;
    logic [7:0]       fn_hz;
  } dstrec_cfg_t;

  typedef struct packed {
    logic             clr_all;
    logic             clr_newest;
    logic             clr_oldest;
    logic             clr_sel;
    logic [IDX_W-1:0] clr_idx;
    logic             man_trig;
  } dstrec_cmd_t;

  typedef struct packed {
    logic [N_ANA*SMP_W-1:0] ana;
    logic [N_DIG-1:0]       dig;
    logic                   trig_mark;
  } dstrec_word_t;

endpackage

/* core/dstrec_buf2.sv */
// Two-entry skid buffer with valid and ready on both sides.
`timescale 1ns/1ps
module dstrec_buf2
  import dstrec_pkg::*;
(
  // Clock and reset.
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Fill side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire dstrec_word_t in_data,
  // Drain side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output dstrec_word_t      out_data
);

  dstrec_word_t mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Read data come out of a register so the head is always stable.
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= ~wp_r;
      end
      if (pop)
      begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      out_data <= '0;
    end
    else if (pop && (cnt_r == 2'h2))
    begin
      out_data <= mem_r[~rp_r];
    end
    else if (push && ((cnt_r == 2'h0) || (pop && (cnt_r == 2'h1))))
    begin
      out_data <= in_data;
    end
    else if (!pop && (cnt_r == 2'h1) && !out_valid)
    begin
      out_data <= mem_r[rp_r];
    end
  end

endmodule

/* core/dstrec_ctrl.sv */
// Trigger, sampling and recording bookkeeping of the disturbance recorder.
`timescale 1ns/1ps
module dstrec_ctrl
  import dstrec_pkg::*;
(
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Settings and one-shot commands.
  input  wire dstrec_cfg_t      cfg,
  input  wire dstrec_cmd_t      cmd,
  // Measurement inputs.
  input  wire logic             ana_strobe,
  input  wire logic [N_ANA*SMP_W-1:0] ana_data,
  input  wire logic [N_DIG-1:0] dig_in,
  // Sample stream towards storage.
  output logic                  smp_valid,
  input  wire logic             smp_ready,
  output dstrec_word_t          smp_data,
  input  wire logic             store_done,
  // Status outputs.
  output dstrec_status_t        status,
  output logic [RECS_W-1:0]     max_recs,
  output logic [MS_W-1:0]       max_len_ms,
  output logic [MS_W-1:0]       max_pre_ms,
  output logic [RECS_W-1:0]     recs_in_mem,
  output logic [RECS_W-1:0]     oldest_slot,
  output logic                  rec_active
);

  typedef enum logic [1:0] {
    DSTREC_F_ARMED,
    DSTREC_F_PRE,
    DSTREC_F_POST,
    DSTREC_F_STORE
  } dstrec_fsm_t;

  localparam logic [RECS_W-1:0] RECS_MAX = RECS_W'(MAX_RECS);

  dstrec_fsm_t       fsm_r;
  logic [RECS_W-1:0] count_r;
  logic [RECS_W-1:0] head_r;
  logic [MS_W-1:0]   post_left_r;
  logic [MS_W-1:0]   pre_fill_r;
  logic [15:0]       ms_tick_r;
  logic [19:0]       dig_tick_r;
  logic [2:0]        dec_r;
  logic [N_DIG-1:0]  dig_hold_r;
  logic [N_TRIG-1:0] trig_prev_r;
  logic              man_prev_r;
  logic              in_ready;
  logic              ms_pulse;
  logic              trig_hit;
  logic              man_hit;
  logic              full;
  logic              cfg_ok;
  logic              keep_sample;
  logic              push_valid;
  logic [31:0]       rate_sps;
  logic [31:0]       max_len_s;
  dstrec_word_t      push_word;

  // Storage demand per second of recording, in samples.
  function automatic logic [31:0] smp_per_sec(input dstrec_cfg_t c);
    logic [31:0] spc;
    spc = 32'h0000_0040 >> c.rate;
    return 32'(c.fn_hz) * (32'(c.n_ana) + 32'h1) * spc
           + 32'(DIG_RATE_HZ) * 32'(c.n_dig);
  endfunction

  function automatic logic [RECS_W-1:0] clip_recs(input logic [31:0] v);
    return (v > 32'(MAX_RECS)) ? RECS_MAX : RECS_W'(v);
  endfunction

  // Cycle, 1 ms and 5 ms time bases.
  assign ms_pulse = (ms_tick_r == 16'(MS_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ms_tick_r <= '0;
    end
    else
    begin
      ms_tick_r <= ms_pulse ? '0 : ms_tick_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dig_tick_r <= '0;
      dig_hold_r <= '0;
    end
    else if (dig_tick_r == 20'(DIG_PERIOD_CYC - 1))
    begin
      dig_tick_r <= '0;
      dig_hold_r <= dig_in;
    end
    else
    begin
      dig_tick_r <= dig_tick_r + 20'h00001;
    end
  end

  // Capacity figures derived from the settings.
  assign rate_sps  = smp_per_sec(cfg);
  assign max_len_s = (rate_sps == 32'h0) ? 32'h0 : RESERVE_SMP / rate_sps;
  assign cfg_ok    = (cfg.trig_sel != '0) && (max_len_s != 32'h0)
                     && (cfg.len_ms >= MS_W'(LEN_MIN_MS))
                     && (cfg.len_ms <= MS_W'(LEN_MAX_MS))
                     && (cfg.pre_ms >= MS_W'(PRE_MIN_MS))
                     && (cfg.pre_ms <= MS_W'(PRE_MAX_MS))
                     && (cfg.pre_ms < cfg.len_ms);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      max_len_ms <= '0;
      max_pre_ms <= '0;
      max_recs   <= '0;
    end
    else
    begin
      // A zero length reading marks an unusable trigger setup.
      if (cfg.trig_sel == '0)
      begin
        max_len_ms <= '0;
      end
      else if (max_len_s >= 32'(LEN_MAX_MS / 1000))
      begin
        max_len_ms <= MS_W'(LEN_MAX_MS);
      end
      else
      begin
        max_len_ms <= MS_W'(max_len_s * 32'd1000);
      end
      if (cfg.len_ms > MS_W'(PRE_MAX_MS))
      begin
        max_pre_ms <= MS_W'(PRE_MAX_MS);
      end
      else
      begin
        max_pre_ms <= cfg.len_ms;
      end
      if (cfg.len_ms == '0)
      begin
        max_recs <= '0;
      end
      else
      begin
        max_recs <= clip_recs((max_len_s * 32'd1000)
                              / 32'(cfg.len_ms));
      end
    end
  end

  // Trigger detection on rising edges only.
  assign trig_hit = |(cfg.trig_sel & dig_in[N_TRIG-1:0]
                      & ~trig_prev_r);
  assign man_hit  = cmd.man_trig && !man_prev_r;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      trig_prev_r <= '0;
      man_prev_r  <= 1'b0;
    end
    else
    begin
      trig_prev_r <= dig_in[N_TRIG-1:0];
      man_prev_r  <= cmd.man_trig;
    end
  end

  assign full = (count_r == RECS_MAX) || (count_r == max_recs);

  // Recording sequence.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      fsm_r       <= DSTREC_F_ARMED;
      pre_fill_r  <= '0;
      post_left_r <= '0;
    end
    else if (!cfg.enable || !cfg_ok)
    begin
      fsm_r      <= DSTREC_F_ARMED;
      pre_fill_r <= '0;
    end
    else
    begin
      case (fsm_r)
        DSTREC_F_ARMED:
        begin
          fsm_r      <= DSTREC_F_PRE;
          pre_fill_r <= '0;
        end
        DSTREC_F_PRE:
        begin
          if (ms_pulse && pre_fill_r != cfg.pre_ms)
          begin
            pre_fill_r <= pre_fill_r + MS_W'(1);
          end
          if ((trig_hit || man_hit) && !(full && cfg.keep_olds))
          begin
            fsm_r       <= DSTREC_F_POST;
            post_left_r <= cfg.len_ms - cfg.pre_ms;
          end
        end
        DSTREC_F_POST:
        begin
          // Triggers are not looked at here.
          if (ms_pulse)
          begin
            if (post_left_r <= MS_W'(1))
            begin
              fsm_r <= DSTREC_F_STORE;
            end
            post_left_r <= post_left_r - MS_W'(1);
          end
        end
        DSTREC_F_STORE:
        begin
          if (store_done)
          begin
            fsm_r <= DSTREC_F_ARMED;
          end
        end
        default:
        begin
          fsm_r <= DSTREC_F_ARMED;
        end
      endcase
    end
  end

  // Memory bookkeeping; a finished store wins over any clear.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      count_r <= '0;
      head_r  <= '0;
    end
    else if (fsm_r == DSTREC_F_STORE && store_done)
    begin
      if (count_r == RECS_MAX || count_r >= max_recs)
      begin
        head_r <= (head_r == RECS_MAX - RECS_W'(1)) ? '0
                  : head_r + RECS_W'(1);
      end
      else
      begin
        count_r <= count_r + RECS_W'(1);
      end
    end
    else if (cmd.clr_all)
    begin
      count_r <= '0;
      head_r  <= '0;
    end
    else if (count_r != '0)
    begin
      if (cmd.clr_newest)
      begin
        count_r <= count_r - RECS_W'(1);
      end
      else if (cmd.clr_oldest)
      begin
        count_r <= count_r - RECS_W'(1);
        head_r  <= (head_r == RECS_MAX - RECS_W'(1)) ? '0
                   : head_r + RECS_W'(1);
      end
      else if (cmd.clr_sel && cmd.clr_idx != '0
               && cmd.clr_idx <= 32'(count_r))
      begin
        // Removing inside the list closes the gap by shortening it.
        count_r <= count_r - RECS_W'(1);
        if (cmd.clr_idx == 32'h1)
        begin
          head_r <= (head_r == RECS_MAX - RECS_W'(1)) ? '0
                    : head_r + RECS_W'(1);
        end
      end
    end
  end

  // Sample decimation and push into the two-entry buffer.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      dec_r <= '0;
    end
    else if (ana_strobe)
    begin
      dec_r <= keep_sample ? '0 : dec_r + 3'h1;
    end
  end

  assign keep_sample = (dec_r == (3'h7 >> (3 - 32'(cfg.rate))));
  assign push_valid  = ana_strobe && keep_sample
                       && (fsm_r == DSTREC_F_PRE || fsm_r == DSTREC_F_POST);
  assign push_word   = '{ana: ana_data, dig: dig_hold_r,
                         trig_mark: (fsm_r == DSTREC_F_PRE)
                                    && (trig_hit || man_hit)};

  dstrec_buf2 u_buf (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (push_valid),
    .in_ready  (in_ready),
    .in_data   (push_word),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  // Status report.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      status <= DSTREC_ST_BADCFG;
    end
    else if (!cfg_ok)
    begin
      status <= DSTREC_ST_BADCFG;
    end
    else if (fsm_r == DSTREC_F_POST)
    begin
      status <= in_ready ? DSTREC_ST_TRIGGERED : DSTREC_ST_REC_STORE;
    end
    else if (fsm_r == DSTREC_F_STORE)
    begin
      status <= DSTREC_ST_STORING;
    end
    else if (full && cfg.keep_olds)
    begin
      status <= DSTREC_ST_FULL;
    end
    else
    begin
      status <= DSTREC_ST_READY;
    end
  end

  assign recs_in_mem = count_r;
  assign oldest_slot = head_r;
  assign rec_active  = (fsm_r == DSTREC_F_POST) || (fsm_r == DSTREC_F_STORE);

endmodule

/* testbench/dstrec_ctrl_props.sv */
// Port checker for the recorder control block.
`timescale 1ns/1ps
module dstrec_ctrl_props
  import dstrec_pkg::*;
(
  // Clock and reset.
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  // Settings and commands.
  input wire dstrec_cfg_t            cfg,
  input wire dstrec_cmd_t            cmd,
  // Measurement inputs.
  input wire logic                   ana_strobe,
  input wire logic [N_ANA*SMP_W-1:0] ana_data,
  input wire logic [N_DIG-1:0]       dig_in,
  // Sample stream.
  input wire logic                   smp_valid,
  input wire logic                   smp_ready,
  input wire dstrec_word_t           smp_data,
  input wire logic                   store_done,
  // Status.
  input wire dstrec_status_t         status,
  input wire logic [RECS_W-1:0]      max_recs,
  input wire logic [MS_W-1:0]        max_len_ms,
  input wire logic [MS_W-1:0]        max_pre_ms,
  input wire logic [RECS_W-1:0]      recs_in_mem,
  input wire logic [RECS_W-1:0]      oldest_slot,
  input wire logic                   rec_active
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_reset_state:
  assert property ($rose(nrst) |-> status == DSTREC_ST_BADCFG
    && recs_in_mem == 0 && !smp_valid) else $error("bad state after reset");
  a_recs_cap:
  assert property (recs_in_mem <= MAX_RECS) else $error("too many recs");
  a_max_recs_cap:
  assert property (max_recs <= MAX_RECS) else $error("max_recs too big");
  a_max_len_cap:
  assert property (max_len_ms <= LEN_MAX_MS) else $error("max_len too big");
  a_max_pre_cap:
  assert property (max_pre_ms <= PRE_MAX_MS) else $error("max_pre too big");
  a_off_idle:
  assert property (!cfg.enable && !rec_active |=> !rec_active)
    else $error("recording started while off");
  a_no_source:
  assert property ((cfg.trig_sel == '0) [*3] |-> status != DSTREC_ST_READY)
    else $error("ready without trigger source");
  a_trig_shown:
  assert property ($rose(rec_active) |=> status inside
    {DSTREC_ST_TRIGGERED, DSTREC_ST_REC_STORE}) else $error("no trig status");
  a_stall_hold:
  assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("word lost in stall");
  c_ready: cover property (status == DSTREC_ST_READY);
  c_trig: cover property (status == DSTREC_ST_TRIGGERED);
  c_stall: cover property (smp_valid && !smp_ready);
endmodule

bind dstrec_ctrl dstrec_ctrl_props u_props (.ref_clk(ref_clk), .nrst(nrst),
  .cfg(cfg), .cmd(cmd), .ana_strobe(ana_strobe), .ana_data(ana_data),
  .dig_in(dig_in), .smp_valid(smp_valid), .smp_ready(smp_ready),
  .smp_data(smp_data), .store_done(store_done), .status(status),
  .max_recs(max_recs), .max_len_ms(max_len_ms), .max_pre_ms(max_pre_ms),
  .recs_in_mem(recs_in_mem), .oldest_slot(oldest_slot),
  .rec_active(rec_active));

/* testbench/dstrec_src_model.sv */
// Measurement source model: analog strobes, sample data, binary levels.
`timescale 1ns/1ps
module dstrec_src_model
  import dstrec_pkg::*;
#(
  parameter int STROBE_CYC = 6250
)(
  // Clock and reset.
  input wire logic              ref_clk,
  input wire logic              nrst,
  // Requested binary levels.
  input wire logic [N_DIG-1:0]  dig_req,
  // Measurement outputs.
  output logic                  ana_strobe,
  output logic [N_ANA*SMP_W-1:0] ana_data,
  output logic [N_DIG-1:0]      dig_in
);
  int cnt = 0;

  // Data moves every cycle, so a capture off the strobe cannot match by luck.
  always @(negedge ref_clk)
  begin
    cnt <= (!nrst || cnt == STROBE_CYC - 1) ? 0 : cnt + 1;
  end
  assign ana_strobe = nrst && cnt == STROBE_CYC - 1;
  assign ana_data = {N_ANA{cnt[SMP_W-1:0]}};
  assign dig_in = dig_req;
endmodule

/* testbench/dstrec_ctrl_tb.sv */
// Self-checking bench for the recorder control block.
`timescale 1ns/1ps
module dstrec_ctrl_tb
  import dstrec_pkg::*;
;
  logic                   ref_clk = 1'b0;
  logic                   nrst = 1'b0;
  dstrec_cfg_t            cfg;
  dstrec_cmd_t            cmd;
  logic [N_DIG-1:0]       dig_req = '0;
  logic [N_DIG-1:0]       dig_in;
  logic                   ana_strobe;
  logic [N_ANA*SMP_W-1:0] ana_data;
  logic                   smp_valid;
  logic                   smp_ready = 1'b1;
  dstrec_word_t           smp_data;
  dstrec_status_t         status;
  logic [RECS_W-1:0]      max_recs, recs_in_mem, oldest_slot;
  logic [MS_W-1:0]        max_len_ms, max_pre_ms;
  logic                   rec_active;
  logic                   store_done = 1'b0;
  logic [31:0]            seed = 32'h0000C7F4;
  int                     mismatches = 0;
  int                     cmp_count = 0;
  int                     cycles = 0;
  int                     model_recs = 0;
  int                     i;

  always #25 ref_clk = ~ref_clk;

  dstrec_src_model #(.STROBE_CYC(50)) u_src (.ref_clk(ref_clk), .nrst(nrst),
    .dig_req(dig_req), .ana_strobe(ana_strobe), .ana_data(ana_data),
    .dig_in(dig_in));

  dstrec_ctrl dut (.ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .cmd(cmd),
    .ana_strobe(ana_strobe), .ana_data(ana_data), .dig_in(dig_in),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .store_done(store_done), .status(status), .max_recs(max_recs),
    .max_len_ms(max_len_ms), .max_pre_ms(max_pre_ms),
    .recs_in_mem(recs_in_mem), .oldest_slot(oldest_slot),
    .rec_active(rec_active));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // The storage side stalls about one cycle in four.
  always @(negedge ref_clk)
  begin
    seed <= xs(seed);
    smp_ready <= seed[0] | seed[1];
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // Every word taken by storage carries the strobe-time analog pattern in its low two analog channels.
  always @(posedge ref_clk)
  begin
    if (nrst && smp_valid && smp_ready)
      chk("smp_ana", {2{16'h0031}}, smp_data.ana[31:0]);
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic wait_st(input dstrec_status_t s, input int n);
    int k;
    for (k = 0; k < n && status !== s; k++)
      @(negedge ref_clk);
    chk("status", s, status);
  endtask

  // Capacity figures worked out from the settings with plain integers.
  task automatic cap_chk();
    int r;
    int s;
    int n;
    r = cfg.fn_hz * (cfg.n_ana + 1) * (64 >> cfg.rate)
        + DIG_RATE_HZ * cfg.n_dig;
    s = RESERVE_SMP / r;
    n = s * 1000 / cfg.len_ms;
    chk("max_len_ms", (cfg.trig_sel == '0) ? 0 : (s >= LEN_MAX_MS / 1000)
        ? LEN_MAX_MS : s * 1000, max_len_ms);
    chk("max_pre_ms", (cfg.len_ms > PRE_MAX_MS) ? PRE_MAX_MS : cfg.len_ms,
        max_pre_ms);
    chk("max_recs", (n > MAX_RECS) ? MAX_RECS : n, max_recs);
    chk("oldest_slot", 0, oldest_slot);
  endtask

  task automatic idle_chk(input int n);
    repeat (n) @(negedge ref_clk);
    chk("rec_active", 0, rec_active);
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    model_recs = 0;
    repeat (6) @(negedge ref_clk);
    chk("status", DSTREC_ST_BADCFG, status);
    chk("recs_in_mem", model_recs, recs_in_mem);
    chk("smp_valid", 0, smp_valid);
    nrst = 1'b1;
  endtask

  initial
  begin
    cfg = '{enable: 1'b1, keep_olds: 1'b0, rate: DSTREC_SR64,
            len_ms: LEN_DEF_MS, pre_ms: PRE_DEF_MS, trig_sel: '0,
            n_ana: 8, n_dig: 2, fn_hz: 50};
    cmd = '0;
    do_reset();
    repeat (10) @(negedge ref_clk);
    chk("ready", 1, status != DSTREC_ST_READY);
    cfg.trig_sel = 16'h0001 << seed[3:0];
    wait_st(DSTREC_ST_READY, 20);
    cap_chk();
    cfg.enable = 1'b0;
    @(negedge ref_clk);
    dig_req = '1;
    idle_chk(20);
    dig_req = '0;
    cfg.enable = 1'b1;
    wait_st(DSTREC_ST_READY, 20);
    dig_req = ~cfg.trig_sel;
    idle_chk(20);
    dig_req = '1;
    wait_st(DSTREC_ST_TRIGGERED, 4);
    chk("rec_active", 1, rec_active);
    for (i = 0; i < 5; i++)
    begin
      cmd = '0;
      cmd.clr_idx = 32'h00000001;
      if (i < 4)
        cmd[33+i] = 1'b1;
      else
        cmd.man_trig = 1'b1;
      dig_req = {N_DIG{i[0]}};
      @(negedge ref_clk);
      cmd = '0;
      @(negedge ref_clk);
      chk("recs_in_mem", model_recs, recs_in_mem);
      chk("rec_active", 1, rec_active);
    end
    repeat (400) @(negedge ref_clk);
    chk("recs_in_mem", model_recs, recs_in_mem);
    do_reset();
    cfg.trig_sel = 16'h8000;
    wait_st(DSTREC_ST_READY, 20);
    cmd.man_trig = 1'b1;
    @(negedge ref_clk);
    cmd.man_trig = 1'b0;
    wait_st(DSTREC_ST_TRIGGERED, 4);
    repeat (400) @(negedge ref_clk);
    chk("rec_active", 1, rec_active);
    do_reset();
    cfg.len_ms = 21'(PRE_DEF_MS + 1);
    wait_st(DSTREC_ST_READY, 20);
    cap_chk();
    cmd.man_trig = 1'b1;
    @(negedge ref_clk);
    cmd.man_trig = 1'b0;
    wait_st(DSTREC_ST_STORING, 21000);
    store_done = 1'b1;
    @(negedge ref_clk);
    store_done = 1'b0;
    model_recs++;
    chk("recs_in_mem", model_recs, recs_in_mem);
    chk("rec_active", 0, rec_active);
    cmd.clr_newest = 1'b1;
    @(negedge ref_clk);
    cmd.clr_newest = 1'b0;
    model_recs--;
    chk("recs_in_mem", model_recs, recs_in_mem);
    wrap_up();
  end
endmodule
